// ---- rtl/pss_defines.svh ----
// Constants for the parallel-to-serial shift register
`ifndef PSS_DEFINES_SVH
`define PSS_DEFINES_SVH

// Number of storage stages in the chain
`define PSS_STAGES     8
// Flip-flops in each pin synchroniser
`define PSS_SYNC_DEPTH 2
// Synchroniser reset levels: strobe idle high, clocks high, data low
`define PSS_RST_LOAD_N 1'h1
`define PSS_RST_CLOCK  1'h1
`define PSS_RST_DATA   1'h0

`endif

// ---- rtl/pss_pkg.sv ----
// Types shared by the shift register design files
`default_nettype none
`include "pss_defines.svh"

package pss_pkg;
  // Contents of the whole shift chain, stage 0 in bit 0
  typedef logic [`PSS_STAGES-1:0] pss_chain_t;
endpackage

`default_nettype wire

// ---- rtl/pss_sync.sv ----
// Two-flop level synchroniser for asynchronous pin inputs
`default_nettype none
`include "pss_defines.svh"

module pss_sync
  import pss_pkg::*;
#(
  parameter int          WIDTH     = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input  wire logic             core_clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] async_in,
  output var  logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_ff;

  // First stage is read only by the second stage
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      meta_ff  <= RST_VAL;
      sync_out <= RST_VAL;
    end
    else
    begin
      meta_ff  <= async_in;
      sync_out <= meta_ff;
    end
  end

endmodule

`default_nettype wire

// ---- rtl/pss_shift.sv ----
// Eight-stage parallel-load, serial-shift register with OR-ed clock inputs
//
// Summary of operation
// - Eight stages 0..7 form one shift chain; stage 7 is last.
// - Load strobe low copies every parallel input into its stage, overriding shifts.
// - Stages follow parallel inputs while strobe low; last value kept on release.
// - Strobe high, combined clock rising: stage 0 takes serial input, others move up.
// - Combined clock is OR of both inputs; either held high blocks shifting.
// - Both clock inputs behave identically and may swap roles.
// - Inhibit rising while other clock low shifts like a clock edge.
// - Last stage drives a true and a complemented serial output.
// - Serial input captured only at the combined clock's rising edge.
`default_nettype none
`include "pss_defines.svh"

module pss_shift
  import pss_pkg::*;
#(
  parameter int STAGES = `PSS_STAGES
) (
  input  wire logic              core_clk,
  input  wire logic              rst,
  input  wire logic              load_strobe_n,
  input  wire logic              serial_in,
  input  wire logic              clock_in_a,
  input  wire logic              clock_in_b,
  input  wire logic [STAGES-1:0] parallel_in,
  output var  logic              serial_out,
  output var  logic              serial_out_n,
  output var  logic [STAGES-2:0] stage_value
);

  localparam int SW = STAGES + 4;
  localparam int CW = $clog2(STAGES + 1);

  logic [SW-1:0]     pin_raw;
  logic [SW-1:0]     pin_sync;
  logic [STAGES-1:0] par_s;
  logic              load_n_s;
  logic              ser_s;
  logic              clk_a_s;
  logic              clk_b_s;
  logic              clk_or;
  logic              clk_or_prev_ff;
  logic              clk_edge;
  logic [STAGES-1:0] stage_ff;
  logic [STAGES-1:0] nxt_stage;
  logic [CW-1:0]     fill_cnt_ff;
  logic              chain_known;

  // All pins are asynchronous to core_clk, so each passes two flops
  assign pin_raw = {load_strobe_n, serial_in, clock_in_a, clock_in_b, parallel_in};

  pss_sync #(
    .WIDTH   (SW),
    .RST_VAL ({`PSS_RST_LOAD_N, `PSS_RST_DATA, `PSS_RST_CLOCK, `PSS_RST_CLOCK,
               {STAGES{`PSS_RST_DATA}}})
  ) u_sync (
    .core_clk (core_clk),
    .rst      (rst),
    .async_in (pin_raw),
    .sync_out (pin_sync)
  );

  assign par_s    = pin_sync[STAGES-1:0];
  assign clk_b_s  = pin_sync[STAGES];
  assign clk_a_s  = pin_sync[STAGES+1];
  assign ser_s    = pin_sync[STAGES+2];
  assign load_n_s = pin_sync[STAGES+3];

  // Both inputs enter one OR, so neither is special
  assign clk_or   = clk_a_s | clk_b_s;
  // Rising OR edge; an inhibit rising while the other is low also counts
  assign clk_edge = clk_or & ~clk_or_prev_ff;

  // Previous OR level; reset high so a clock already high at release is no edge
  always_ff @(posedge core_clk)
  begin
    if (rst)
      clk_or_prev_ff <= `PSS_RST_CLOCK;
    else
      clk_or_prev_ff <= clk_or;
  end

  // Next chain value: load wins, else shift on edge, else hold
  always_comb
  begin
    nxt_stage = stage_ff;
    if (!load_n_s)
      nxt_stage = par_s;
    else if (clk_edge)
      nxt_stage = {stage_ff[STAGES-2:0], ser_s};
  end

  // Chain storage carries no reset on purpose, like the discrete part
  always_ff @(posedge core_clk)
  begin
    stage_ff <= nxt_stage;
  end

  // Outputs registered from the same next value, so they track stage_ff
  always_ff @(posedge core_clk)
  begin
    serial_out   <= nxt_stage[STAGES-1];
    serial_out_n <= ~nxt_stage[STAGES-1];
    stage_value  <= nxt_stage[STAGES-2:0];
  end

  // Check-only fill tracker: stages are unknown until a load or a full fill,
  // so value checks wait for it; a mid-run reset makes it cautious again
  always_ff @(posedge core_clk)
  begin
    if (rst)
      fill_cnt_ff <= '0;
    else if (!load_n_s)
      fill_cnt_ff <= CW'(STAGES);
    else if (clk_edge && !chain_known)
      fill_cnt_ff <= fill_cnt_ff + CW'(1);
  end

  // Whole chain holds defined values
  assign chain_known = (fill_cnt_ff == CW'(STAGES));

  // Checks
  // Checks during a load or of stage 0 alone run ungated; the rest wait for the fill tracker, since the chain has no reset
  sequence seq_shift_step;
    load_n_s && clk_edge;
  endsequence

  sequence seq_load_held;
    !load_n_s [*2];
  endsequence

  sequence seq_load_release;
    !load_n_s ##1 load_n_s;
  endsequence

  chk_load_copies: assert property (
    @(posedge core_clk) disable iff (rst)
    !load_n_s |=> stage_ff == $past(par_s))
    else $error("parallel load not copied");

  chk_load_follows: assert property (
    @(posedge core_clk) disable iff (rst)
    seq_load_held |=> stage_ff == $past(par_s) && {serial_out_n, serial_out} != 2'h0)
    else $error("stages not following parallel inputs");

  chk_load_retain: assert property (
    @(posedge core_clk) disable iff (rst)
    seq_load_release ##0 !clk_edge |=> stage_ff == $past(par_s, 2))
    else $error("loaded value not retained");

  chk_shift_move: assert property (
    @(posedge core_clk) disable iff (rst)
    chain_known ##0 seq_shift_step
    |=> stage_ff == {$past(stage_ff[STAGES-2:0]), $past(ser_s)})
    else $error("shift step wrong");

  chk_hold_a: assert property (
    @(posedge core_clk) disable iff (rst)
    chain_known && load_n_s && clk_a_s && $past(clk_a_s) |=> stage_ff == $past(stage_ff))
    else $error("clock a high did not inhibit");

  chk_hold_b: assert property (
    @(posedge core_clk) disable iff (rst)
    chain_known && load_n_s && clk_b_s && $past(clk_b_s) |=> stage_ff == $past(stage_ff))
    else $error("clock b high did not inhibit");

  chk_inhibit_rise: assert property (
    @(posedge core_clk) disable iff (rst)
    load_n_s && $rose(clk_b_s) && !clk_a_s && !$past(clk_a_s)
    |=> stage_ff[0] == $past(ser_s))
    else $error("inhibit rise did not shift");

  chk_true_out: assert property (
    @(posedge core_clk) disable iff (rst)
    chain_known |-> serial_out == stage_ff[STAGES-1] && stage_value == stage_ff[STAGES-2:0])
    else $error("serial output differs from last stage");

  chk_comp_known: assert property (
    @(posedge core_clk) disable iff (rst)
    chain_known |-> serial_out_n == !serial_out)
    else $error("complement output not inverse of true output");

  chk_idle_hold: assert property (
    @(posedge core_clk) disable iff (rst)
    chain_known && load_n_s && !clk_edge |=> stage_ff == $past(stage_ff))
    else $error("chain changed without clock edge");

  chk_shift_out: assert property (
    @(posedge core_clk) disable iff (rst)
    chain_known ##0 seq_shift_step |=> serial_out == $past(stage_ff[STAGES-2]))
    else $error("serial output did not take stage below");

  chk_a_rise: assert property (
    @(posedge core_clk) disable iff (rst)
    load_n_s && $rose(clk_a_s) && !clk_b_s && !$past(clk_b_s)
    |=> stage_ff[0] == $past(ser_s))
    else $error("clock a rise did not shift");

  // One check per link of the chain, so a broken stage is named
  for (genvar gi = 1; gi < STAGES; gi++)
  begin : g_link
    chk_link_move: assert property (
      @(posedge core_clk) disable iff (rst)
      chain_known ##0 seq_shift_step |=> stage_ff[gi] == $past(stage_ff[gi-1]))
      else $error("stage link did not shift");
  end

  chk_comp_out: assert property (
    @(posedge core_clk) disable iff (rst)
    !load_n_s |=> serial_out_n == !serial_out)
    else $error("complement output wrong");

endmodule

`default_nettype wire

// ---- sim/pss_ctrl_model.sv ----
// Controller model that drives the shift register pins
`default_nettype none
module pss_ctrl_model (
  input  wire logic       core_clk,
  output var  logic       load_strobe_n,
  output var  logic       serial_in,
  output var  logic       clock_in_a,
  output var  logic       clock_in_b,
  output var  logic [7:0] parallel_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle pins: no load, both clocks low
  initial
  begin
    load_strobe_n = 1'h1;
    serial_in = 1'h0;
    clock_in_a = 1'h0;
    clock_in_b = 1'h0;
    parallel_in = 8'h00;
  end
  // Levels last 4 cycles, as pins pass a synchroniser
  task automatic step(int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  // Data settles before the clocks move and stays after
  task automatic set(logic a, logic b, logic d);
    serial_in = d;
    step(4);
    clock_in_a = a;
    clock_in_b = b;
    step(4);
  endtask
  // A clock edge inside the load is tried on purpose
  task automatic load(logic [7:0] p1, logic [7:0] p2);
    parallel_in = p1;
    load_strobe_n = 1'h0;
    clock_in_a = 1'h1;
    step(4);
    parallel_in = p2;
    clock_in_a = 1'h0;
    step(4);
    load_strobe_n = 1'h1;
    step(4);
  endtask
endmodule
`default_nettype wire

// ---- sim/testbench.sv ----
// Self-checking bench for the eight-stage shift register
`default_nettype none
module testbench
  import pss_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic            core_clk = 1'h0;
  logic            rst = 1'h1;
  wire logic       ld_n, sin, ca, cb;
  wire logic [7:0] pin;
  logic            so, so_n;
  logic [6:0]      sv;
  pss_chain_t      exp_q[$];
  pss_chain_t      e, exp_chain;
  int              n_mismatch = 0;
  int              samples_checked = 0;
  event            ev;
  // Clock generator
  always #12.5 core_clk = ~core_clk;
  pss_ctrl_model u_pss_ctrl_model (.core_clk(core_clk), .load_strobe_n(ld_n), .serial_in(sin),
    .clock_in_a(ca), .clock_in_b(cb), .parallel_in(pin));
  pss_shift #(.STAGES(8)) u_pss_shift (.core_clk(core_clk), .rst(rst),
    .load_strobe_n(ld_n), .serial_in(sin), .clock_in_a(ca), .clock_in_b(cb),
    .parallel_in(pin), .serial_out(so), .serial_out_n(so_n), .stage_value(sv));
  task automatic check(string nm, logic [7:0] seen, logic [7:0] want);
    samples_checked++;
    if (seen !== want)
    begin
      n_mismatch++;
      $display("unexpected %s exp %h got %h", nm, want, seen);
    end
  endtask
  task automatic summarize();
    $display("compared %0d mismatched %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic note();
    exp_q.push_back(exp_chain);
    ->ev;
  endtask
  // Only a rise of the OR of both clocks shifts
  task automatic drv(logic a, logic b, logic d);
    logic rise;
    rise = !(ca | cb) && (a | b);
    u_pss_ctrl_model.set(a, b, d);
    if (rise)
      exp_chain = {exp_chain[6:0], d};
    note();
  endtask
  task automatic ld(pss_chain_t p1, pss_chain_t p2);
    u_pss_ctrl_model.load(p1, p2);
    exp_chain = p2;
    note();
  endtask
  // Watcher: oldest note against settled outputs
  initial
    forever
    begin
      @ev;
      e = exp_q.pop_front();
      check("serial_out", {6'h00, so_n, so}, {6'h00, ~e[7], e[7]});
      check("stage_value", {1'h0, sv}, {1'h0, e[6:0]});
    end
  // Hang guard
  initial
  begin
    repeat (3000) @(posedge core_clk);
    n_mismatch++;
    summarize();
  end
  initial
  begin
    void'($urandom(32'h6dc1_c9ca));
    repeat (12) @(posedge core_clk);
    #1 rst = 1'h0;
    u_pss_ctrl_model.step(4);
    ld(pss_chain_t'($urandom), pss_chain_t'($urandom));
    // Eight shifts on each input fill the chain twice
    for (int i = 0; i < 16; i++)
    begin
      logic d;
      d = 1'($urandom);
      drv(!i[3], i[3], d);
      drv(1'h0, 1'h0, d);
    end
    drv(1'h1, 1'h0, 1'h1);
    drv(1'h1, 1'h1, 1'h0);
    drv(1'h0, 1'h1, 1'h1);
    drv(1'h1, 1'h1, 1'h1);
    drv(1'h0, 1'h0, 1'h0);
    drv(1'h0, 1'h1, 1'h1);
    drv(1'h0, 1'h0, 1'h0);
    ld(pss_chain_t'($urandom), pss_chain_t'($urandom));
    u_pss_ctrl_model.step(2);
    summarize();
  end
endmodule
`default_nettype wire
